//--- logic/usds_pkg.sv
`include "usds_regs.svh"
package usds_pkg;
  typedef enum logic [2:0] {RX_IDLE = 3'h1, RX_START = 3'h2, RX_BITS = 3'h4} usds_rx_fsm_type;
  typedef enum logic [1:0] {TX_IDLE = 2'h1, TX_SEND = 2'h2} usds_tx_fsm_type;
  typedef enum logic [2:0] {LIN_DATA = 3'h1, LIN_SYNC = 3'h2, LIN_PID = 3'h4} usds_lin_type;
  typedef struct packed {
    logic ovf;
    logic framing_error_flag;
    logic parity_error_flag;
    logic [8:0] data;
  } usds_entry_type;
  typedef struct packed {
    logic [2:0] sync;
    logic line;
    usds_rx_fsm_type state;
    logic [15:0] cnt;
    logic [3:0] idx;
    logic [8:0] sh;
    logic par;
    logic valid;
    logic start;
    logic framing_error_flag;
    logic parity_error_flag;
    logic [8:0] data;
  } usds_rx_state_type;
  typedef struct packed {
    usds_tx_fsm_type state;
    logic [11:0] sh;
    logic [3:0] left;
    logic [15:0] cnt;
    logic txd;
    logic done;
  } usds_tx_state_type;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] ctrl_c;
    logic [15:0] baud;
    logic [7:0] dbg;
    logic [7:0] evc;
    logic [7:0] txpl;
    logic [7:0] rxpl;
    usds_entry_type [1:0] ent;
    logic rd_ptr;
    logic [1:0] count;
    logic wait_v;
    usds_entry_type wait_e;
    usds_lin_type lin_ph;
    logic [8:0] tx_buf;
    logic tx_full;
    logic tx_wait_hi;
    logic tx_hi;
    logic txc;
  } usds_top_state_type;

  function automatic logic [3:0] usds_nbits(input logic [2:0] cs);
    case (cs)
      3'h0: usds_nbits = 4'h5;
      3'h1: usds_nbits = 4'h6;
      3'h2: usds_nbits = 4'h7;
      `USDS_CS_9LOW, `USDS_CS_9HIGH: usds_nbits = 4'h9;
      default: usds_nbits = 4'h8;
    endcase
  endfunction : usds_nbits

  function automatic logic [15:0] usds_period(input logic [15:0] baud);
    usds_period = (baud == 16'h0000) ? 16'h0001 : baud;
  endfunction : usds_period
endpackage : usds_pkg

//--- logic/usds_regs.svh
`ifndef USDS_REGS_SVH
`define USDS_REGS_SVH
// ==========================================
// Register indices (byte address = 4 * index)
`define USDS_IDX_RXL 6'h00
`define USDS_IDX_RXH 6'h01
`define USDS_IDX_TXL 6'h02
`define USDS_IDX_TXH 6'h03
`define USDS_IDX_STAT 6'h04
`define USDS_IDX_CTA 6'h05
`define USDS_IDX_CTB 6'h06
`define USDS_IDX_CTC 6'h07
`define USDS_IDX_BDL 6'h08
`define USDS_IDX_BDH 6'h09
`define USDS_IDX_RSV 6'h0A
`define USDS_IDX_DBG 6'h0B
`define USDS_IDX_EVC 6'h0C
`define USDS_IDX_TXPL 6'h0D
`define USDS_IDX_RXPL 6'h0E
// ==========================================
// Field positions
`define USDS_RX_COMPLETE_FLAG 7
`define USDS_TX_COMPLETE_FLAG 6
`define USDS_TX_BUFFER_EMPTY_FLAG 5
`define USDS_OVF 6
`define USDS_FRAMING_ERROR_FLAG 2
`define USDS_PARITY_ERROR_FLAG 1
`define USDS_RXEN 7
`define USDS_TXEN 6
`define USDS_STOP_BITS_SELECT 3
// ==========================================
// Field codes and reset values
`define USDS_CMODE_MSPI 2'h3
`define USDS_RXMODE_LIN 2'h3
`define USDS_CS_9LOW 3'h6
`define USDS_CS_9HIGH 3'h7
`define USDS_RST_BYTE 8'h00
`define USDS_RST_BAUD 16'h0000
`endif

//--- logic/usds_rx.sv
`timescale 1ns/1ps
module usds_rx import usds_pkg::*; (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Line and setup
  input wire logic i_rxd,
  input wire logic i_en,
  input wire logic [3:0] i_nbits,
  input wire logic i_par_en,
  input wire logic i_par_odd,
  input wire logic [15:0] i_baud,
  // Character out
  output logic o_valid,
  output logic o_start,
  output logic o_framing_error_flag,
  output logic o_parity_error_flag,
  output logic [8:0] o_data
);
  usds_rx_state_type st_q, st_d;
  logic [15:0] per;

  assign per = usds_period(i_baud);

  // ==========================================
  // Receive sequencer
  always_comb begin
    st_d = st_q;
    st_d.valid = 1'b0;
    st_d.start = 1'b0;
    st_d.sync = {st_q.sync[1:0], i_rxd};
    if (st_q.sync[1] == st_q.sync[2]) begin
      st_d.line = st_q.sync[2];
    end
    case (st_q.state)
      RX_IDLE: begin
        if (i_en && !st_q.line) begin
          st_d.state = RX_START;
          st_d.cnt = per >> 1;
          st_d.start = 1'b1;
        end
      end
      RX_START: begin
        if (st_q.cnt != 16'h0000) begin
          st_d.cnt = st_q.cnt - 16'h0001;
        end else if (st_q.line) begin
          st_d.state = RX_IDLE;
        end else begin
          st_d.state = RX_BITS;
          st_d.cnt = per - 16'h0001;
          st_d.idx = 4'h0;
          st_d.sh = 9'h000;
          st_d.par = i_par_odd;
        end
      end
      RX_BITS: begin
        if (st_q.cnt != 16'h0000) begin
          st_d.cnt = st_q.cnt - 16'h0001;
        end else begin
          st_d.cnt = per - 16'h0001;
          if (st_q.idx < i_nbits) begin
            st_d.sh = {st_q.line, st_q.sh[8:1]};
            st_d.par = st_q.par ^ st_q.line;
            st_d.idx = st_q.idx + 4'h1;
          end else if (i_par_en && st_q.idx == i_nbits) begin
            st_d.par = st_q.par ^ st_q.line;
            st_d.idx = st_q.idx + 4'h1;
          end else begin
            st_d.state = RX_IDLE;
            st_d.valid = 1'b1;
            st_d.framing_error_flag = ~st_q.line;
            st_d.parity_error_flag = i_par_en & st_q.par;
            st_d.data = st_q.sh >> (4'h9 - i_nbits);
          end
        end
      end
      default: st_d.state = RX_IDLE;
    endcase
    if (!i_en) begin
      st_d.state = RX_IDLE;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q <= '0;
      st_q.state <= RX_IDLE;
      st_q.sync <= 3'h7;
      st_q.line <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_valid = st_q.valid;
  assign o_start = st_q.start;
  assign o_framing_error_flag = st_q.framing_error_flag;
  assign o_parity_error_flag = st_q.parity_error_flag;
  assign o_data = st_q.data;
endmodule : usds_rx

//--- logic/usds_top.sv
`timescale 1ns/1ps
// Behaviour
// - two-entry receive FIFO, read advances head
// - receive flag tracks buffer, disable flushes
// - overflow on full buffer, waiting char, start
// - framing flag from first stop bit
// - parity flag only with checking enabled, except LIN identifier
// - LIN mode parity reports identifier check
// - LIN mode ninth bit marks identifier/response
// - master SPI leaves error flags unused
// - short characters: upper bits ignored/zero
// - transmit write taken only when empty
// - buffer moves to idle shifter, then sent
// - transmit high byte: write-only ninth bit
// - empty flag set at reset, cleared by write
// - transmit complete sticky, cleared by one
module usds_top import usds_pkg::*; (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Serial line
  input wire logic i_rxd,
  output logic o_txd,
  // Interrupt
  input wire logic i_txc_ack,
  output logic o_irq
);
  usds_top_state_type st_q, st_d;
  logic [5:0] idx;
  logic acc;
  logic wr;
  logic rd;
  logic [7:0] wb;
  logic [7:0] rd_byte;
  logic [3:0] nb;
  logic lin;
  logic mspi;
  logic lowfirst;
  logic rxen;
  logic txen;
  logic rx_complete_flag;
  logic par_en;
  logic rx_valid;
  logic rx_start;
  logic rx_framing_error_flag;
  logic rx_parity_error_flag;
  logic [8:0] rx_data;
  logic tx_load;
  logic tx_idle;
  logic tx_done;
  logic tx_txd;
  usds_entry_type head;
  usds_entry_type inc;
  logic [1:0] cnt;
  logic ptr;
  logic keep;

  function automatic logic usds_mapped(input logic [5:0] a);
    usds_mapped = (a <= `USDS_IDX_RXPL) && (a != `USDS_IDX_RSV);
  endfunction : usds_mapped

  function automatic logic usds_pid_bad(input logic [7:0] p);
    usds_pid_bad = (p[6] != (p[0] ^ p[1] ^ p[2] ^ p[4])) | (p[7] != ~(p[1] ^ p[3] ^ p[4] ^ p[5]));
  endfunction : usds_pid_bad

  // ==========================================
  // Decode
  assign idx = i_paddr[7:2];
  assign acc = i_psel & i_penable & st_q.pready & usds_mapped(idx);
  assign wr = acc & i_pwrite;
  assign rd = acc & ~i_pwrite;
  assign wb = i_pwdata[7:0];
  assign nb = usds_nbits(st_q.ctrl_c[2:0]);
  assign lin = (st_q.ctrl_b[2:1] == `USDS_RXMODE_LIN);
  assign mspi = (st_q.ctrl_c[7:6] == `USDS_CMODE_MSPI);
  assign lowfirst = (st_q.ctrl_c[2:0] == `USDS_CS_9LOW);
  assign rxen = st_q.ctrl_b[`USDS_RXEN];
  assign txen = st_q.ctrl_b[`USDS_TXEN];
  assign par_en = st_q.ctrl_c[5];
  assign rx_complete_flag = (st_q.count != 2'h0);
  assign head = st_q.ent[st_q.rd_ptr];
  assign tx_load = st_q.tx_full & ~st_q.tx_wait_hi & txen & tx_idle;

  // ==========================================
  // Line engines
  usds_rx u_rx (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_rxd(i_rxd),
    .i_en(rxen),
    .i_nbits(nb),
    .i_par_en(par_en),
    .i_par_odd(st_q.ctrl_c[4]),
    .i_baud(st_q.baud),
    .o_valid(rx_valid),
    .o_start(rx_start),
    .o_framing_error_flag(rx_framing_error_flag),
    .o_parity_error_flag(rx_parity_error_flag),
    .o_data(rx_data)
  );

  usds_tx u_tx (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_load(tx_load),
    .i_data(st_q.tx_buf),
    .i_nbits(nb),
    .i_par_en(par_en),
    .i_par_odd(st_q.ctrl_c[4]),
    .i_two_stop(st_q.ctrl_c[`USDS_STOP_BITS_SELECT]),
    .i_baud(st_q.baud),
    .o_txd(tx_txd),
    .o_idle(tx_idle),
    .o_done(tx_done)
  );

  // ==========================================
  // Read mux
  always_comb begin
    rd_byte = `USDS_RST_BYTE;
    case (idx)
      `USDS_IDX_RXL: rd_byte = head.data[7:0];
      `USDS_IDX_RXH: rd_byte = rx_complete_flag ? {rx_complete_flag, head.ovf, 3'h0, head.framing_error_flag, head.parity_error_flag, head.data[8]} : `USDS_RST_BYTE;
      `USDS_IDX_TXL: rd_byte = st_q.tx_buf[7:0];
      `USDS_IDX_STAT: rd_byte = {rx_complete_flag, st_q.txc, ~st_q.tx_full, 5'h00};
      `USDS_IDX_CTA: rd_byte = st_q.ctrl_a;
      `USDS_IDX_CTB: rd_byte = st_q.ctrl_b;
      `USDS_IDX_CTC: rd_byte = st_q.ctrl_c;
      `USDS_IDX_BDL: rd_byte = st_q.baud[7:0];
      `USDS_IDX_BDH: rd_byte = st_q.baud[15:8];
      `USDS_IDX_DBG: rd_byte = st_q.dbg;
      `USDS_IDX_EVC: rd_byte = st_q.evc;
      `USDS_IDX_TXPL: rd_byte = st_q.txpl;
      `USDS_IDX_RXPL: rd_byte = st_q.rxpl;
      default: rd_byte = `USDS_RST_BYTE;
    endcase
  end

  // ==========================================
  // Next state
  always_comb begin
    st_d = st_q;
    cnt = st_q.count;
    ptr = st_q.rd_ptr;
    inc = '0;
    keep = 1'b0;
    // APB answer one cycle into the access phase
    st_d.pready = 1'b0;
    st_d.pslverr = 1'b0;
    if (i_psel && i_penable && !st_q.pready) begin
      st_d.pready = 1'b1;
      st_d.pslverr = ~usds_mapped(idx);
      st_d.prdata = {24'h000000, rd_byte};
    end
    // Receive FIFO pop
    if (rd && cnt != 2'h0 && idx == (lowfirst ? `USDS_IDX_RXH : `USDS_IDX_RXL)) begin
      ptr = ~ptr;
      cnt = cnt - 2'h1;
    end
    // Overflow marks the character now at the head
    if (rx_start && cnt == 2'h2 && st_q.wait_v && !mspi) begin
      st_d.ent[ptr].ovf = 1'b1;
    end
    // Waiting character moves into the FIFO
    st_d.wait_v = st_q.wait_v;
    if (st_q.wait_v && cnt != 2'h2) begin
      st_d.ent[ptr ^ cnt[0]] = st_q.wait_e;
      cnt = cnt + 2'h1;
      st_d.wait_v = 1'b0;
    end
    // New character from the line
    if (rx_valid) begin
      inc.data = rx_data;
      inc.framing_error_flag = rx_framing_error_flag & ~mspi;
      inc.parity_error_flag = rx_parity_error_flag & par_en & ~mspi;
      keep = 1'b1;
      if (lin) begin
        if (rx_framing_error_flag && rx_data[7:0] == 8'h00) begin
          st_d.lin_ph = LIN_SYNC;
          keep = 1'b0;
        end else if (st_q.lin_ph == LIN_SYNC) begin
          st_d.lin_ph = LIN_PID;
          keep = 1'b0;
        end else if (st_q.lin_ph == LIN_PID) begin
          st_d.lin_ph = LIN_DATA;
          inc.data[8] = 1'b0;
          inc.parity_error_flag = usds_pid_bad(rx_data[7:0]) & ~mspi;
        end else begin
          inc.data[8] = 1'b1;
          inc.parity_error_flag = 1'b0;
        end
      end
      if (keep && !st_d.wait_v) begin
        st_d.wait_v = 1'b1;
        st_d.wait_e = inc;
      end
    end
    // Receiver off flushes everything
    if (!rxen) begin
      cnt = 2'h0;
      st_d.wait_v = 1'b0;
      st_d.lin_ph = LIN_DATA;
    end
    st_d.count = cnt;
    st_d.rd_ptr = ptr;
    // Shifter takes the buffer
    if (tx_load) begin
      st_d.tx_full = 1'b0;
    end
    // Register writes
    if (wr) begin
      case (idx)
        `USDS_IDX_TXL: begin
          if (!st_q.tx_full) begin
            st_d.tx_buf[7:0] = wb;
            st_d.tx_buf[8] = st_q.tx_hi & ~mspi;
            st_d.tx_full = 1'b1;
            st_d.tx_wait_hi = lowfirst;
          end
        end
        `USDS_IDX_TXH: begin
          st_d.tx_hi = wb[0];
          if (st_q.tx_wait_hi) begin
            st_d.tx_buf[8] = wb[0] & ~mspi;
            st_d.tx_wait_hi = 1'b0;
          end
        end
        `USDS_IDX_STAT: begin
          if (wb[`USDS_TX_COMPLETE_FLAG]) begin
            st_d.txc = 1'b0;
          end
        end
        `USDS_IDX_CTA: st_d.ctrl_a = wb;
        `USDS_IDX_CTB: st_d.ctrl_b = wb;
        `USDS_IDX_CTC: st_d.ctrl_c = wb;
        `USDS_IDX_BDL: st_d.baud[7:0] = wb;
        `USDS_IDX_BDH: st_d.baud[15:8] = wb;
        `USDS_IDX_DBG: st_d.dbg = wb;
        `USDS_IDX_EVC: st_d.evc = wb;
        `USDS_IDX_TXPL: st_d.txpl = wb;
        `USDS_IDX_RXPL: st_d.rxpl = wb;
        default: st_d.ctrl_a = st_q.ctrl_a;
      endcase
    end
    // Transmit complete: vector entry clears, set wins
    if (i_txc_ack) begin
      st_d.txc = 1'b0;
    end
    if (tx_done && !st_q.tx_full) begin
      st_d.txc = 1'b1;
    end
    // Interrupt line from next flag values
    st_d.irq = |({st_d.count != 2'h0, st_d.txc, ~st_d.tx_full} & st_d.ctrl_a[7:5]);
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q <= '0;
      st_q.lin_ph <= LIN_DATA;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================
  // Outputs
  assign o_prdata = st_q.prdata;
  assign o_pready = st_q.pready;
  assign o_pslverr = st_q.pslverr;
  assign o_irq = st_q.irq;
  assign o_txd = tx_txd;
endmodule : usds_top

//--- logic/usds_tx.sv
`timescale 1ns/1ps
module usds_tx import usds_pkg::*; (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Character in
  input wire logic i_load,
  input wire logic [8:0] i_data,
  input wire logic [3:0] i_nbits,
  input wire logic i_par_en,
  input wire logic i_par_odd,
  input wire logic i_two_stop,
  input wire logic [15:0] i_baud,
  // Line and status
  output logic o_txd,
  output logic o_idle,
  output logic o_done
);
  usds_tx_state_type st_q, st_d;
  logic [12:0] frame;
  logic [8:0] masked;
  logic [15:0] per;

  assign per = usds_period(i_baud);

  // ==========================================
  // Frame builder
  always_comb begin
    masked = 9'h000;
    frame = 13'h1FFF;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(i_nbits)) begin
        masked[i] = i_data[i];
      end
    end
    frame[0] = 1'b0;
    frame[9:1] = masked;
    for (int i = 0; i < 9; i++) begin
      if (i >= int'(i_nbits)) begin
        frame[i + 1] = 1'b1;
      end
    end
    if (i_par_en) begin
      frame[i_nbits + 4'h1] = (^masked) ^ i_par_odd;
    end
  end

  // ==========================================
  // Shifter
  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    case (st_q.state)
      TX_IDLE: begin
        st_d.txd = 1'b1;
        if (i_load) begin
          st_d.state = TX_SEND;
          st_d.txd = frame[0];
          st_d.sh = frame[12:1];
          st_d.left = i_nbits + {3'h0, i_par_en} + {3'h0, i_two_stop} + 4'h1;
          st_d.cnt = per - 16'h0001;
        end
      end
      TX_SEND: begin
        if (st_q.cnt != 16'h0000) begin
          st_d.cnt = st_q.cnt - 16'h0001;
        end else if (st_q.left != 4'h0) begin
          st_d.txd = st_q.sh[0];
          st_d.sh = {1'b1, st_q.sh[11:1]};
          st_d.left = st_q.left - 4'h1;
          st_d.cnt = per - 16'h0001;
        end else begin
          st_d.state = TX_IDLE;
          st_d.done = 1'b1;
        end
      end
      default: st_d.state = TX_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q <= '0;
      st_q.state <= TX_IDLE;
      st_q.txd <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_txd = st_q.txd;
  assign o_idle = (st_q.state == TX_IDLE);
  assign o_done = st_q.done;
endmodule : usds_tx

//--- verif/usds_line_model.sv
`timescale 1ns/1ps
// ====
// Serial peer
module usds_line_model (
  // Clock
  input wire logic i_ref_clk,
  // Setup
  input wire logic [3:0] i_nbits,
  input wire logic [15:0] i_bit,
  // Line
  input wire logic i_txd,
  output logic o_rxd,
  // Character seen on transmit line
  output logic o_got,
  output logic [8:0] o_char
);
  logic [8:0] sh;
  initial begin
    o_rxd = 1'b1;
    o_got = 1'b0;
    o_char = 9'h000;
  end
  task automatic put(input logic b);
    @(posedge i_ref_clk);
    o_rxd <= b;
    repeat (i_bit - 16'h0001) @(posedge i_ref_clk);
  endtask : put
  // Frame: start, data LSB first, parity, stop, idle bit
  task automatic send(input logic [8:0] d, input logic [3:0] n, input logic pe, input logic pb, input logic sb);
    logic p;
    p = pb;
    put(1'b0);
    for (int k = 0; k < n; k++) begin
      put(d[k]);
      p = p ^ d[k];
    end
    if (pe) put(p);
    put(!sb);
    put(1'b1);
  endtask : send
  // Decode transmit line at mid bit
  always begin
    @(negedge i_txd);
    sh = 9'h000;
    repeat (i_bit / 2) @(posedge i_ref_clk);
    for (int k = 0; k < i_nbits; k++) begin
      repeat (i_bit) @(posedge i_ref_clk);
      sh[k] = i_txd;
    end
    repeat (i_bit) @(posedge i_ref_clk);
    o_got <= 1'b1;
    o_char <= sh;
    @(posedge i_ref_clk);
    o_got <= 1'b0;
  end
endmodule : usds_line_model

//--- verif/usds_top_bench.sv
`timescale 1ns/1ps
`include "usds_regs.svh"
// ====
// Bench top
module usds_top_bench;
  logic i_ref_clk, i_sys_rst, i_psel, i_penable, i_pwrite, i_txc_ack, i_rxd;
  logic [7:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata;
  logic o_pready, o_pslverr, o_txd, o_irq, m_got;
  logic [8:0] m_char;
  logic [3:0] nbits;
  logic [7:0] a, e;
  logic [7:0] q [4];
  logic [32:0] rdq [$];
  logic [8:0] txq [$];
  int err_count, check_count, seed;
  usds_top u_usds_top (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_rxd(i_rxd),
    .o_txd(o_txd), .i_txc_ack(i_txc_ack), .o_irq(o_irq));
  usds_line_model u_usds_line_model (.i_ref_clk(i_ref_clk), .i_nbits(nbits), .i_bit(16'h0004),
    .i_txd(o_txd), .o_rxd(i_rxd), .o_got(m_got), .o_char(m_char));
  // ====
  // Tasks
  task check(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task close_out;
    if (err_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] d, input logic [8:0] x);
    int n;
    @(posedge i_ref_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= {idx, 2'h0};
    i_pwdata <= {24'h000000, d};
    if (!w) rdq.push_back({x[8], 24'h000000, x[7:0]});
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (!o_pready && n < 20);
    if (o_pready) begin
      i_psel <= 1'b0;
      i_penable <= 1'b0;
    end else begin
      err_count++;
      close_out();
    end
  endtask : apb
  task wr(input logic [5:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 9'h000);
  endtask : wr
  task rd(input logic [5:0] idx, input logic [8:0] x);
    apb(1'b0, idx, 8'h00, x);
  endtask : rd
  task tick(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask : tick
  task irq_is(input logic v);
    tick(3);
    check({32'h00000000, o_irq}, {32'h00000000, v});
  endtask : irq_is
  task rx(input logic [8:0] d, input logic [3:0] n, input logic pb, input logic sb, input logic pe);
    u_usds_line_model.send(d, n, pe, pb, sb);
    tick(8);
  endtask : rx
  task drain;
    for (int k = 0; k < 3000 && txq.size() > 0; k++) @(posedge i_ref_clk);
    if (txq.size() > 0) begin
      err_count++;
      close_out();
    end else begin
      tick(12);
    end
  endtask : drain
  // ====
  // Result watcher
  always @(posedge i_ref_clk) begin
    if (i_psel && i_penable && o_pready && !i_pwrite) begin
      if (rdq.size() > 0) check({o_pslverr, o_prdata}, rdq.pop_front());
      else err_count++;
    end
    if (m_got) begin
      if (txq.size() > 0) check({24'h000000, m_char}, {24'h000000, txq.pop_front()});
      else err_count++;
    end
  end
  initial begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    tick(100000);
    err_count++;
    close_out();
  end
  // ====
  // Main sequence
  initial begin
    {i_sys_rst, i_psel, i_penable, i_pwrite, i_txc_ack} = 5'h10;
    i_paddr = 8'h00;
    i_pwdata = 32'h00000000;
    nbits = 4'h8;
    seed = 78173;
    tick(5);
    i_sys_rst <= 1'b0;
    rd(`USDS_IDX_STAT, 9'h020);
    rd(`USDS_IDX_RXH, 9'h000);
    rd(`USDS_IDX_RXL, 9'h000);
    rd(`USDS_IDX_TXH, 9'h000);
    rd(`USDS_IDX_RSV, 9'h100);
    rd(6'h3F, 9'h100);
    wr(`USDS_IDX_BDL, 8'h04);
    wr(`USDS_IDX_CTC, 8'h03);
    wr(`USDS_IDX_CTB, 8'hC0);
    for (int k = 0; k < 3; k++) begin
      a = $random(seed);
      if (k < 2) txq.push_back({1'b0, a});
      wr(`USDS_IDX_TXL, a);
    end
    drain();
    rd(`USDS_IDX_STAT, 9'h060);
    wr(`USDS_IDX_CTA, 8'h40);
    irq_is(1'b1);
    wr(`USDS_IDX_CTA, 8'h00);
    irq_is(1'b0);
    wr(`USDS_IDX_CTA, 8'h40);
    irq_is(1'b1);
    i_txc_ack <= 1'b1;
    tick(1);
    i_txc_ack <= 1'b0;
    irq_is(1'b0);
    rd(`USDS_IDX_STAT, 9'h020);
    wr(`USDS_IDX_CTA, 8'h20);
    irq_is(1'b1);
    wr(`USDS_IDX_CTA, 8'h80);
    for (int k = 0; k < 4; k++) begin
      q[k] = $random(seed);
      u_usds_line_model.send({1'b0, q[k]}, 4'h8, 1'b0, 1'b0, k == 1);
    end
    irq_is(1'b1);
    rd(`USDS_IDX_RXH, 9'h0C0);
    rd(`USDS_IDX_RXL, {1'b0, q[0]});
    rd(`USDS_IDX_RXH, 9'h084);
    rd(`USDS_IDX_RXL, {1'b0, q[1]});
    tick(8);
    rd(`USDS_IDX_RXH, 9'h080);
    rd(`USDS_IDX_RXL, {1'b0, q[2]});
    rd(`USDS_IDX_RXH, 9'h000);
    wr(`USDS_IDX_CTA, 8'h00);
    e = $random(seed);
    wr(`USDS_IDX_CTC, 8'h23);
    rx({1'b0, e}, 4'h8, 1'b1, 1'b0, 1'b1);
    rd(`USDS_IDX_RXH, 9'h082);
    rd(`USDS_IDX_RXL, {1'b0, e});
    wr(`USDS_IDX_CTC, 8'hC3);
    rx({1'b0, e}, 4'h8, 1'b0, 1'b1, 1'b0);
    rd(`USDS_IDX_RXH, 9'h080);
    rd(`USDS_IDX_RXL, {1'b0, e});
    rx({1'b0, e}, 4'h8, 1'b0, 1'b0, 1'b0);
    wr(`USDS_IDX_CTB, 8'h40);
    rd(`USDS_IDX_RXH, 9'h000);
    wr(`USDS_IDX_CTC, 8'h03);
    wr(`USDS_IDX_CTB, 8'hC6);
    u_usds_line_model.send(9'h000, 4'h8, 1'b0, 1'b0, 1'b1);
    u_usds_line_model.send(9'h055, 4'h8, 1'b0, 1'b0, 1'b0);
    u_usds_line_model.send(9'h000, 4'h8, 1'b0, 1'b0, 1'b0);
    rx({1'b0, e}, 4'h8, 1'b0, 1'b0, 1'b0);
    rd(`USDS_IDX_RXH, 9'h082);
    rd(`USDS_IDX_RXL, 9'h000);
    rd(`USDS_IDX_RXH, 9'h081);
    rd(`USDS_IDX_RXL, {1'b0, e});
    wr(`USDS_IDX_CTB, 8'hC0);
    wr(`USDS_IDX_CTC, 8'h00);
    nbits <= 4'h5;
    rx({1'b0, e}, 4'h5, 1'b0, 1'b0, 1'b0);
    rd(`USDS_IDX_RXL, {4'h0, e[4:0]});
    a = $random(seed);
    txq.push_back({4'h0, a[4:0]});
    wr(`USDS_IDX_TXL, a);
    drain();
    wr(`USDS_IDX_STAT, 8'h40);
    rd(`USDS_IDX_STAT, 9'h020);
    wr(`USDS_IDX_CTC, 8'h07);
    nbits <= 4'h9;
    wr(`USDS_IDX_TXH, 8'h01);
    txq.push_back({1'b1, a});
    wr(`USDS_IDX_TXL, a);
    drain();
    rx({1'b1, e}, 4'h9, 1'b0, 1'b0, 1'b0);
    rd(`USDS_IDX_RXH, 9'h081);
    rd(`USDS_IDX_RXL, {1'b0, e});
    wr(`USDS_IDX_CTC, 8'h06);
    txq.push_back({1'b0, a});
    wr(`USDS_IDX_TXL, a);
    wr(`USDS_IDX_TXH, 8'h00);
    drain();
    rx({1'b1, e}, 4'h9, 1'b0, 1'b0, 1'b0);
    rd(`USDS_IDX_RXL, {1'b0, e});
    rd(`USDS_IDX_RXH, 9'h081);
    rd(`USDS_IDX_RXH, 9'h000);
    close_out();
  end
endmodule : usds_top_bench

//--- verif/usds_top_checker.sv
`timescale 1ns/1ps
`include "usds_regs.svh"
// ====
// Port checker
module usds_top_checker (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // APB
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Interrupt
  input wire logic o_irq
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  logic [5:0] idx;
  logic done;
  assign idx = i_paddr[7:2];
  assign done = i_psel && i_penable && o_pready;
  sequence s_rx_off;
    done && i_pwrite && idx == `USDS_IDX_CTB && !i_pwdata[7];
  endsequence
  sequence s_rd_rxh;
    done && !i_pwrite && idx == `USDS_IDX_RXH;
  endsequence
  sequence s_mask_all;
    done && i_pwrite && idx == `USDS_IDX_CTA && i_pwdata[7:5] == 3'h0;
  endsequence
  AST_PREADY_PULSE: assert property (o_pready |=> !o_pready)
    else $error("ready held too long");
  AST_ONE_WAIT: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("access not answered after one wait");
  AST_NO_SPURIOUS: assert property (o_pready |-> $past(i_psel && i_penable))
    else $error("ready without access");
  AST_ERR_MAP: assert property (o_pready |-> o_pslverr == (idx == `USDS_IDX_RSV || idx > `USDS_IDX_RXPL))
    else $error("error response does not match map");
  AST_UPPER_ZERO: assert property (o_pready |-> o_prdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  AST_TXH_WO: assert property (done && !i_pwrite && idx == `USDS_IDX_TXH |-> o_prdata[7:0] == 8'h00)
    else $error("transmit high byte readable");
  AST_STAT_RSVD: assert property (done && !i_pwrite && idx == `USDS_IDX_STAT |-> o_prdata[4:0] == 5'h00)
    else $error("unused status bits set");
  AST_RXH_RSVD: assert property (s_rd_rxh |-> o_prdata[5:3] == 3'h0)
    else $error("unused flag bits set");
  AST_FLUSH: assert property (s_rx_off ##[1:8] s_rd_rxh |-> !o_prdata[7])
    else $error("receive flag left after disable");
  AST_IRQ_MASK: assert property (s_mask_all |-> ##2 !o_irq)
    else $error("interrupt while all masked");
endmodule : usds_top_checker

bind usds_top usds_top_checker u_usds_top_checker (.i_ref_clk, .i_sys_rst, .i_psel, .i_penable,
  .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_irq);
